// file: dfw_defs.svh
`ifndef DFW_DEFS_SVH
`define DFW_DEFS_SVH

// ----------------------------------------------------------------------------
// register indices on the plain register port
// ----------------------------------------------------------------------------
`define DFW_A_ERR        4'h0
`define DFW_A_WARN       4'h1
`define DFW_A_STAT       4'h2
`define DFW_A_CMD        4'h3
`define DFW_A_ISTS       4'h4
`define DFW_A_IMSK       4'h5
`define DFW_A_HIST0      4'h6
`define DFW_A_HIST4      4'hA

// ----------------------------------------------------------------------------
// field layouts and reset values
// ----------------------------------------------------------------------------
`define DFW_ERR_MASK     32'h01C5_3FFF
`define DFW_ERR_RST      32'h0000_0000
`define DFW_WARN_RST     8'h00
`define DFW_IRQ_RST      4'h0
`define DFW_CODE_NONE    16'h0000
`define DFW_ST_PF_MSB    15
`define DFW_ST_PF_LSB    14
`define DFW_ST_ERR_BIT   13
`define DFW_ST_WARN_BIT  11
`define DFW_PW_TEST      2'b00
`define DFW_PW_READY     2'b01
`define DFW_PW_POWER     2'b10
`define DFW_PW_TORQUE    2'b11
`define DFW_CMD_DIAG     0
`define DFW_CMD_HIST     1
`define DFW_IRQ_ERR      0
`define DFW_IRQ_WARN     1
`define DFW_IRQ_DIAG     2
`define DFW_IRQ_HIST     3
`define DFW_HIST_N       5
`define DFW_ERR_BITS     25

`endif

// file: dfw_pkg.sv
package dfw_pkg;
    typedef logic [15:0] dfw_code_t;
    typedef enum logic [2:0] {ST_TEST, ST_READY, ST_POWER, ST_TORQUE, ST_FAULT} dfw_pstate_t;
    typedef enum logic [1:0] {DR_IDLE, DR_STATUS, DR_READY} dfw_dr_t;
endpackage

// file: dfw_hist_if.sv
`timescale 1ns/100ps
interface dfw_hist_if;
    import dfw_pkg::*;
    logic      push;
    dfw_code_t code;
    logic      clear;
    dfw_code_t entry [0:4];
    modport owner (input push, input code, input clear, output entry);
    modport user  (output push, output code, output clear, input entry);
endinterface

// file: dfw_hist.sv
`timescale 1ns/100ps
`include "dfw_defs.svh"
module dfw_hist
    import dfw_pkg::*;
(
    input  wire logic  i_clk_sys,
    input  wire logic  i_rstn,
    dfw_hist_if.owner  hist
);
    dfw_code_t mem_q [0:`DFW_HIST_N-1];

    // ------------------------------------------------------------------------
    // five most recent errors, newest in entry 0
    // ------------------------------------------------------------------------
    // shift in newest
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < `DFW_HIST_N; i++) mem_q[i] <= `DFW_CODE_NONE;
        end else if (hist.clear) begin
            for (int i = 0; i < `DFW_HIST_N; i++) mem_q[i] <= `DFW_CODE_NONE;
        end else if (hist.push) begin
            mem_q[0] <= hist.code;
            for (int i = 1; i < `DFW_HIST_N; i++) mem_q[i] <= mem_q[i-1];
        end
    end

    always_comb begin
        for (int i = 0; i < `DFW_HIST_N; i++) hist.entry[i] = mem_q[i];
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_hist_clear;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        hist.clear |=> (mem_q[0] == `DFW_CODE_NONE) && (mem_q[4] == `DFW_CODE_NONE);
    endproperty
    a_hist_clear: assert property (p_hist_clear) else $error("history not zeroed");

    property p_hist_push;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (hist.push && !hist.clear) |=> (mem_q[0] == $past(hist.code))
            && (mem_q[4] == $past(mem_q[3]));
    endproperty
    a_hist_push: assert property (p_hist_push) else $error("history push wrong");
endmodule

// file: dfw_top.sv
`timescale 1ns/100ps
`include "dfw_defs.svh"
module dfw_top
    import dfw_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic [31:0] i_fault,
    input  wire logic [7:0]  i_warn,
    input  wire logic        i_selftest_done,
    input  wire logic        i_power_ok,
    input  wire logic        i_torque_req,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic      [1:0]  o_power_state,
    output logic             o_fault,
    output logic             o_irq
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [31:0] err_q;
    logic [31:0] err_d;
    logic [7:0]  warn_q;
    logic        stat_err_q;
    logic        toggle_q;
    logic [3:0]  ists_q;
    logic [3:0]  ists_d;
    logic [3:0]  imsk_q;
    logic [31:0] rdata_q;
    logic        irq_q;
    logic [1:0]  pf_q;
    dfw_pstate_t pst_q;
    dfw_pstate_t pst_d;
    dfw_dr_t     dr_q;
    dfw_dr_t     dr_d;

    dfw_hist_if  hist ();

    dfw_hist u_hist (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .hist      (hist)
    );

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // error number shown for each flag position
    function automatic dfw_code_t err_code(input logic [4:0] b);
        unique case (b)
            5'h00:   err_code = 16'h0001;
            5'h01:   err_code = 16'h0004;
            5'h02:   err_code = 16'h006A;
            5'h03:   err_code = 16'h006C;
            5'h04:   err_code = 16'h00C8;
            5'h05:   err_code = 16'h00C9;
            5'h06:   err_code = 16'h00CA;
            5'h07:   err_code = 16'h00D6;
            5'h08:   err_code = 16'h0130;
            5'h09:   err_code = 16'h0133;
            5'h0A:   err_code = 16'h0003;
            5'h0B:   err_code = 16'h013A;
            5'h0C:   err_code = 16'h0321;
            5'h0D:   err_code = 16'h0322;
            5'h10:   err_code = 16'h0323;
            5'h12:   err_code = 16'h01FE;
            5'h16:   err_code = 16'h009C;
            5'h17:   err_code = 16'h01FA;
            5'h18:   err_code = 16'h01F6;
            default: err_code = `DFW_CODE_NONE;
        endcase
    endfunction

    // lowest set bit; only one new error is logged per cycle
    function automatic logic [4:0] first_bit(input logic [31:0] v);
        first_bit = 5'h00;
        for (int i = `DFW_ERR_BITS - 1; i >= 0; i--) begin
            if (v[i]) first_bit = 5'(i);
        end
    endfunction

    function automatic logic [1:0] pf_code(input dfw_pstate_t s);
        unique case (s)
            ST_READY:  pf_code = `DFW_PW_READY;
            ST_POWER:  pf_code = `DFW_PW_POWER;
            ST_TORQUE: pf_code = `DFW_PW_TORQUE;
            ST_TEST:   pf_code = `DFW_PW_TEST;
            ST_FAULT:  pf_code = `DFW_PW_TEST;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------------
    wire        wr_cmd   = i_wr && (i_addr == `DFW_A_CMD);
    wire        wr_ists  = i_wr && (i_addr == `DFW_A_ISTS);
    wire        wr_imsk  = i_wr && (i_addr == `DFW_A_IMSK);
    wire        diag_cmd = wr_cmd && i_wdata[`DFW_CMD_DIAG];
    wire        hist_cmd = wr_cmd && i_wdata[`DFW_CMD_HIST];
    wire        diag_clr = (dr_q == DR_STATUS);
    wire [31:0] fault_m  = i_fault & `DFW_ERR_MASK;
    wire [31:0] new_err  = fault_m & ~err_q;
    wire        any_new  = |new_err;
    wire        new_warn = |(i_warn & ~warn_q);
    wire        any_err  = |err_q;
    wire [15:0] stat_w   = {pf_q, stat_err_q, 1'b0, |warn_q, 10'h000, toggle_q};
    wire [3:0]  hidx     = i_addr - `DFW_A_HIST0;
    wire        hist_hit = (i_addr >= `DFW_A_HIST0) && (i_addr <= `DFW_A_HIST4);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hist_hit) begin
            rd_mux = {16'h0000, hist.entry[hidx[2:0]]};
        end else begin
            unique case (i_addr)
                `DFW_A_ERR:  rd_mux = err_q;
                `DFW_A_WARN: rd_mux = {24'h000000, warn_q};
                `DFW_A_STAT: rd_mux = {16'h0000, stat_w};
                `DFW_A_ISTS: rd_mux = {28'h0000000, ists_q};
                `DFW_A_IMSK: rd_mux = {28'h0000000, imsk_q};
                default:     rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // error and warning flags
    // ------------------------------------------------------------------------
    // sticky fault flags
    // cleared by diagnostics reset; a fault still present sets again
    assign err_d = diag_clr ? fault_m : (err_q | fault_m);

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            err_q <= `DFW_ERR_RST;
        end else begin
            err_q <= err_d;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            warn_q <= `DFW_WARN_RST;
        end else begin
            warn_q <= i_warn;
        end
    end

    assign hist.push  = any_new;
    assign hist.code  = err_code(first_bit(new_err));
    assign hist.clear = hist_cmd;

    // ------------------------------------------------------------------------
    // diagnostics reset sequence
    // ------------------------------------------------------------------------
    always_comb begin
        dr_d = dr_q;
        unique case (dr_q)
            DR_IDLE:   if (diag_cmd) dr_d = DR_STATUS;
            DR_STATUS: dr_d = DR_READY;
            DR_READY:  dr_d = DR_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            dr_q <= DR_IDLE;
        end else begin
            dr_q <= dr_d;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            stat_err_q <= 1'b0;
        end else begin
            stat_err_q <= |err_d;
        end
    end

    // bit 0 of the status word toggles on every read of the status word so the host can see it fresh
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            toggle_q <= 1'b0;
        end else if (i_rd && (i_addr == `DFW_A_STAT)) begin
            toggle_q <= ~toggle_q;
        end
    end

    // ------------------------------------------------------------------------
    // power and torque state
    // ------------------------------------------------------------------------
    always_comb begin
        pst_d = pst_q;
        if (dr_q == DR_READY) begin
            pst_d = ST_READY;
        end else if (any_err) begin
            pst_d = ST_FAULT;
        end else begin
            unique case (pst_q)
                ST_TEST:   if (i_selftest_done) pst_d = ST_READY;
                ST_READY:  if (i_power_ok) pst_d = ST_POWER;
                ST_POWER: begin
                    if (!i_power_ok) pst_d = ST_READY;
                    else if (i_torque_req) pst_d = ST_TORQUE;
                end
                ST_TORQUE: begin
                    if (!i_power_ok) pst_d = ST_READY;
                    else if (!i_torque_req) pst_d = ST_POWER;
                end
                ST_FAULT:  pst_d = ST_FAULT;
            endcase
        end
    end

    // fault state holds until software asks for a diagnostics reset
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pst_q <= ST_TEST;
            pf_q  <= `DFW_PW_TEST;
        end else begin
            pst_q <= pst_d;
            pf_q  <= pf_code(pst_d);
        end
    end

    // ------------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------------
    // a new event in the clearing cycle wins over the write-one clear
    wire [3:0] ev = {hist_cmd, dr_q == DR_READY, new_warn, any_new};
    assign ists_d = (ists_q & ~(wr_ists ? i_wdata[3:0] : 4'h0)) | ev;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ists_q <= `DFW_IRQ_RST;
            imsk_q <= `DFW_IRQ_RST;
            irq_q  <= 1'b0;
        end else begin
            ists_q <= ists_d;
            if (wr_imsk) imsk_q <= i_wdata[3:0];
            irq_q  <= |(ists_d & (wr_imsk ? i_wdata[3:0] : imsk_q));
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= i_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign o_rdata       = rdata_q;
    assign o_power_state = pf_q;
    assign o_fault       = stat_err_q;
    assign o_irq         = irq_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_err_set;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (|(i_fault & `DFW_ERR_MASK)) |=> ((err_q & $past(i_fault & `DFW_ERR_MASK))
            == $past(i_fault & `DFW_ERR_MASK));
    endproperty
    a_err_set: assert property (p_err_set) else $error("fault flag not raised");

    property p_warn;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        1'b1 |=> (warn_q == $past(i_warn));
    endproperty
    a_warn: assert property (p_warn) else $error("warning flags wrong");

    property p_diag_clear;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (diag_cmd && dr_q == DR_IDLE) ##1 (i_fault == 32'h0000_0000)
            |=> (err_q == 32'h0000_0000);
    endproperty
    a_diag_clear: assert property (p_diag_clear) else $error("errors not cleared");

    property p_stat_first;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (dr_q == DR_STATUS) |=> (stat_err_q == (|err_q)) && (dr_q == DR_READY);
    endproperty
    a_stat_first: assert property (p_stat_first) else $error("status not updated first");

    property p_ready;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (diag_cmd && dr_q == DR_IDLE) |-> ##3 (pst_q == ST_READY);
    endproperty
    a_ready: assert property (p_ready) else $error("not awaiting power after reset");

    property p_keep_hist;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (dr_q != DR_IDLE && !hist_cmd && !any_new) |=> $stable(hist.entry[0]);
    endproperty
    a_keep_hist: assert property (p_keep_hist) else $error("memory lost on reset");

    property p_hist_cmd;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        hist_cmd |=> (hist.entry[2] == `DFW_CODE_NONE) && ists_q[`DFW_IRQ_HIST];
    endproperty
    a_hist_cmd: assert property (p_hist_cmd) else $error("history not cleared");

    property p_hist_log;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (any_new && !hist_cmd) |=> (hist.entry[0] != `DFW_CODE_NONE);
    endproperty
    a_hist_log: assert property (p_hist_log) else $error("error not logged");

    property p_pf_ready;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (pst_q == ST_READY) |-> (pf_q == `DFW_PW_READY);
    endproperty
    a_pf_ready: assert property (p_pf_ready) else $error("power field not 0,1");

    property p_reserved;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (err_q & ~`DFW_ERR_MASK) == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved error bit set");

    property p_irq;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (|(ists_q & imsk_q)) |-> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule

// file: dfw_host.sv
`timescale 1ns/100ps
`include "dfw_defs.svh"
// ----------------------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------------------
module dfw_host (
    input  wire logic        i_clk_sys,
    input  wire logic [31:0] i_rdata,
    output logic      [3:0]  o_addr,
    output logic      [31:0] o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    initial begin
        o_addr  = 4'hF;
        o_wdata = 32'hA5A5_5A5A;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    // data is inverted once the strobe drops, so a stale word never looks valid
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk_sys);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk_sys);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask

    task automatic diag_reset();
        wr(`DFW_A_CMD, 32'h0000_0001);
    endtask
endmodule

// file: tb_drive_fault_warning_flags.sv
`timescale 1ns/100ps
`include "dfw_defs.svh"
module tb_drive_fault_warning_flags;
    import dfw_pkg::*;
    logic        i_clk_sys;
    logic        i_rstn;
    logic [31:0] i_fault;
    logic [7:0]  i_warn;
    logic        i_selftest_done;
    logic        i_power_ok;
    logic        i_torque_req;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [1:0]  o_power_state;
    logic        o_fault;
    logic        o_irq;
    logic [31:0] rv;
    int          bad_count;
    int          compares;
    int          n;
    // error numbers of flag bits 0..7
    logic [15:0] err_num [0:7] = '{16'h0001, 16'h0004, 16'h006A, 16'h006C,
                                   16'h00C8, 16'h00C9, 16'h00CA, 16'h00D6};

    dfw_top uut (
        .i_clk_sys      (i_clk_sys),
        .i_rstn         (i_rstn),
        .i_fault        (i_fault),
        .i_warn         (i_warn),
        .i_selftest_done(i_selftest_done),
        .i_power_ok     (i_power_ok),
        .i_torque_req   (i_torque_req),
        .i_addr         (addr),
        .i_wdata        (wdata),
        .i_wr           (wr),
        .i_rd           (rd),
        .o_rdata        (rdata),
        .o_power_state  (o_power_state),
        .o_fault        (o_fault),
        .o_irq          (o_irq)
    );

    dfw_host host (
        .i_clk_sys(i_clk_sys),
        .i_rdata  (rdata),
        .o_addr   (addr),
        .o_wdata  (wdata),
        .o_wr     (wr),
        .o_rd     (rd)
    );

    always #25 i_clk_sys = ~i_clk_sys;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        host.rd(a, d);
        chk(d, exp, what);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------------
    initial begin
        i_clk_sys       = 1'b0;
        i_rstn          = 1'b0;
        i_fault         = 32'h0000_0000;
        i_warn          = 8'h00;
        i_selftest_done = 1'b0;
        i_power_ok      = 1'b0;
        i_torque_req    = 1'b0;
        bad_count       = 0;
        compares        = 0;
        repeat (10) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        cyc(3);
        chk({30'h0, o_power_state}, 32'h0000_0000, "internal test");
        @(posedge i_clk_sys);
        i_selftest_done <= 1'b1;
        rchk(`DFW_A_ERR, 32'h0000_0000, "err reset");
        rchk(`DFW_A_WARN, 32'h0000_0000, "warn reset");
        rchk(`DFW_A_ISTS, 32'h0000_0000, "ists reset");
        rchk(`DFW_A_IMSK, 32'h0000_0000, "imsk reset");
        rchk(`DFW_A_CMD, 32'h0000_0000, "cmd reads zero");
        rchk(4'hF, 32'h0000_0000, "unmapped read");
        for (int k = 0; k < 5; k++) rchk(`DFW_A_HIST0 + 4'(k), 32'h0000_0000, "hist reset");
        chk({30'h0, o_power_state}, 32'h0000_0001, "ready after test");
        $display("test reset values done");

        for (int k = 0; k < 8; k++) begin
            @(posedge i_clk_sys);
            i_warn <= 8'h01 << k;
            cyc(2);
            rchk(`DFW_A_WARN, 32'h0000_0001 << k, "warn bit");
        end
        @(posedge i_clk_sys);
        i_warn <= 8'h00;
        $display("test warning bits done");

        for (int k = 2; k < 8; k++) begin
            @(posedge i_clk_sys);
            i_fault <= i_fault | (32'h0000_0001 << k);
            cyc(3);
        end
        for (int k = 0; k < 5; k++) rchk(`DFW_A_HIST0 + 4'(k), {16'h0, err_num[7-k]}, "hist");
        chk({31'h0, o_fault}, 32'h0000_0001, "fault shown");
        chk({30'h0, o_power_state}, 32'h0000_0000, "fault state");
        $display("test history order done");

        @(posedge i_clk_sys);
        i_fault <= 32'hFFFF_FFFF;
        cyc(3);
        rchk(`DFW_A_ERR, `DFW_ERR_MASK, "err flags");
        rchk(`DFW_A_HIST0, {16'h0, err_num[0]}, "lowest pushed");
        host.wr(`DFW_A_ERR, 32'h0000_0000);
        rchk(`DFW_A_ERR, `DFW_ERR_MASK, "err read only");
        $display("test error flags done");

        rchk(`DFW_A_ISTS, 32'h0000_0003, "ists events");
        chk({31'h0, o_irq}, 32'h0000_0000, "irq masked");
        host.wr(`DFW_A_IMSK, 32'h0000_0001);
        cyc(2);
        chk({31'h0, o_irq}, 32'h0000_0001, "irq raised");
        rchk(`DFW_A_IMSK, 32'h0000_0001, "imsk rw");
        host.wr(`DFW_A_ISTS, 32'h0000_0001);
        cyc(2);
        chk({31'h0, o_irq}, 32'h0000_0000, "irq cleared");
        rchk(`DFW_A_ISTS, 32'h0000_0002, "ists w1c");
        $display("test interrupts done");

        @(posedge i_clk_sys);
        i_fault <= 32'h0000_0000;
        host.diag_reset();
        n = 0;
        while (o_fault !== 1'b0 && n < 20) begin
            cyc(1);
            n++;
        end
        // a timeout only counts; the run still ends in test_done below
        if (o_fault !== 1'b0) begin
            bad_count++;
            $display("[ERR] %0t fault indication never cleared", $time);
        end
        chk({31'h0, o_power_state == 2'b01}, 32'h0000_0000, "status before ready");
        cyc(1);
        chk({30'h0, o_power_state}, 32'h0000_0001, "awaiting power");
        rchk(`DFW_A_ERR, 32'h0000_0000, "errors cleared");
        host.rd(`DFW_A_STAT, rv);
        chk({29'h0, rv[15:13]}, 32'h0000_0002, "status word");
        cyc(1);
        chk(rdata, 32'h0000_0000, "read data drops");
        host.rd(`DFW_A_STAT, rv);
        chk({31'h0, rv[0]}, 32'h0000_0001, "toggle bit");
        rchk(`DFW_A_HIST0, {16'h0, err_num[0]}, "hist kept");
        rchk(`DFW_A_ISTS, 32'h0000_0006, "diag done event");
        $display("test diagnostics reset done");

        @(posedge i_clk_sys);
        i_fault <= 32'h0000_2000;
        cyc(3);
        host.diag_reset();
        cyc(4);
        rchk(`DFW_A_ERR, 32'h0000_2000, "fault persists");
        chk({31'h0, o_fault}, 32'h0000_0001, "fault kept");
        rchk(`DFW_A_HIST0, 32'h0000_0322, "encoder error");
        @(posedge i_clk_sys);
        i_fault <= 32'h0000_0000;
        host.diag_reset();
        cyc(4);
        chk({31'h0, o_fault}, 32'h0000_0000, "fault gone");
        $display("test persistent fault done");

        host.wr(`DFW_A_ISTS, 32'h0000_000F);
        host.wr(`DFW_A_CMD, 32'h0000_0002);
        cyc(2);
        for (int k = 0; k < 5; k++) rchk(`DFW_A_HIST0 + 4'(k), 32'h0000_0000, "hist zero");
        rchk(`DFW_A_ISTS, 32'h0000_0008, "hist clear event");
        $display("test history clear done");

        @(posedge i_clk_sys);
        i_power_ok <= 1'b1;
        cyc(3);
        chk({30'h0, o_power_state}, 32'h0000_0002, "power on");
        @(posedge i_clk_sys);
        i_torque_req <= 1'b1;
        cyc(3);
        chk({30'h0, o_power_state}, 32'h0000_0003, "torque on");
        @(posedge i_clk_sys);
        i_torque_req <= 1'b0;
        cyc(3);
        chk({30'h0, o_power_state}, 32'h0000_0002, "torque off");
        $display("test power states done");
        test_done();
    end
endmodule
